// ### shared/sclk_defines.vh
`ifndef SCLK_DEFINES_VH
`define SCLK_DEFINES_VH

// ****************************************************************
// Register word indices; the Wishbone byte address is four times
// the index.
// ****************************************************************
`define SCLK_IDX_FREQ_A    16'hfe0a
`define SCLK_IDX_FREQ_B    16'hfe0b
`define SCLK_IDX_FREQ_C    16'hfe0c
`define SCLK_IDX_DELAY     16'hfe0d
`define SCLK_IDX_SYNC_CTL  16'hfe0e
`define SCLK_IDX_PIN_FUNC  16'hfe0f
`define SCLK_IDX_STATUS    16'hfe40

// ****************************************************************
// Reset values and field positions.
// ****************************************************************
`define SCLK_RST_BYTE      8'h00
`define SCLK_MULT_HI       7
`define SCLK_MULT_LO       6
`define SCLK_CODE_HI       5
`define SCLK_MULT_X2       2'h1
`define SCLK_SEL_BIT       3
`define SCLK_PIN_IN_BIT    0
`define SCLK_PIN_OUT_BIT   3

// ****************************************************************
// Timing, in nanoseconds.
// ****************************************************************
`define SCLK_CLK_NS        8
`define SCLK_PROP_NS       760
`define SCLK_STEP_NS       80

`endif

// ### test/sclk_props.sv
`timescale 1ns/1ps
// ****************************************
// Port checks of the switching clock block.
// ****************************************
module sclk_props #(
  parameter AW = 18,
  parameter PW = 12
) (
  input wire          clk_i,
  input wire          rst_i,
  input wire [AW-1:0] adr_i,
  input wire [31:0]   dat_i,
  input wire [31:0]   dat_o,
  input wire          we_i,
  input wire [3:0]    sel_i,
  input wire          cyc_i,
  input wire          stb_i,
  input wire          ack_o,
  input wire          shared_flag_sync_input_i,
  input wire [2:0]    chan_clk_o,
  input wire          shared_flag_sync_output_o,
  input wire          shared_flag_sync_output_oe_o
);
  wire oe  = shared_flag_sync_output_oe_o;
  wire out = shared_flag_sync_output_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> s_ack)
    else $error("bus request not answered in one cycle");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_DAT_BYTE: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_OUT_SEL: assert property (oe && $past(oe) |->
    out == $past(chan_clk_o[0]) || out == $past(chan_clk_o[2]))
    else $error("sync output follows no selectable channel");
  AST_FLAG_LOW: assert property (!oe |-> !out)
    else $error("sync output driven while not enabled");
  AST_OE_REL: assert property ($fell(rst_i) |-> !oe ##1 oe)
    else $error("sync output enable wrong after reset");
  AST_RST_CLR: assert property ($fell(rst_i) |->
    chan_clk_o == 3'h0 && !ack_o && !out)
    else $error("outputs not cleared by reset");
  AST_HIGH_MIN: assert property ($rose(chan_clk_o[0]) |->
    chan_clk_o[0] [*8])
    else $error("channel clock high phase too short");
endmodule // sclk_props

bind sclk_top sclk_props #(.AW(AW), .PW(PW)) i_sclk_props (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o),
  .shared_flag_sync_input_i(shared_flag_sync_input_i),
  .chan_clk_o(chan_clk_o),
  .shared_flag_sync_output_o(shared_flag_sync_output_o),
  .shared_flag_sync_output_oe_o(shared_flag_sync_output_oe_o));

// ### test/sclk_sync_src.sv
`timescale 1ns/1ps
// ****************************************
// External sync source, one link pulse per frame.
// ****************************************
module sclk_sync_src (
  input  wire  en_i,
  output logic sync_o
);
  // The line idles low between frames, as a pull-down would hold it.
  initial begin
    sync_o = 1'b0;
    #3;
    forever begin
      if (en_i) begin
        sync_o = 1'b1;
        #32;
        sync_o = 1'b0;
        #3168;
      end
      else begin
        #64;
      end
    end
  end
endmodule // sclk_sync_src

// ### test/testbench.sv
`timescale 1ns/1ps
// ****************************************
// Bench of the switching clock block.
// ****************************************
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [17:0] adr_i = 18'h0;
  logic [31:0] dat_i = 32'h0;
  logic        we_i  = 1'b0;
  logic [3:0]  sel_i = 4'hf;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        run   = 1'b0;
  logic [31:0] q;
  wire         pin;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire         out_o;
  wire         oe_o;
  wire  [2:0]  chan_clk_o;
  int          miscompares = 0;
  int          check_count = 0;
  int          n;
  int          a;
  logic [15:0] rows [8][3] = '{'{16'hfe0a, 16'h5a, 16'h5a},
    '{16'hfe0b, 16'ha5, 16'ha5}, '{16'hfe0c, 16'h3c, 16'h3c},
    '{16'hfe0d, 16'hc3, 16'hc3}, '{16'hfe0e, 16'hf0, 16'hf0},
    '{16'hfe0f, 16'h36, 16'h36}, '{16'hfe20, 16'hff, 16'h00},
    '{16'hfe0b, 16'h00, 16'h00}};

  always #4 clk_i = ~clk_i;

  sclk_top i_sclk_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .shared_flag_sync_input_i(pin), .chan_clk_o(chan_clk_o),
    .shared_flag_sync_output_o(out_o),
    .shared_flag_sync_output_oe_o(oe_o));
  sclk_sync_src i_sclk_sync_src (.en_i(run), .sync_o(pin));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, hi, g);
    check_count++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic wb(input logic w, input logic [15:0] ix,
                    input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      stop_test;
    end
  endtask

  function automatic logic sv(input int ch);
    return (ch == 3) ? pin : chan_clk_o[ch];
  endfunction

  // Counts edges up to the next sampled rise; index 3 is the sync pin.
  task automatic rising(input int ch);
    logic o;
    n = 1;
    o = sv(ch);
    @(posedge clk_i);
    while (!(o === 1'b0 && sv(ch) === 1'b1) && n < 6000) begin
      o = sv(ch);
      @(posedge clk_i);
      n++;
    end
    if (n >= 6000) begin
      miscompares++;
      stop_test;
    end
  endtask

  task automatic per(input int ch, input int e);
    rising(ch);
    rising(ch);
    chk("period", e, n);
  endtask

  task automatic follow(input int ch);
    logic o;
    o = chan_clk_o[ch];
    repeat (600) begin
      @(posedge clk_i);
      chk("sync out", o, out_o);
      o = chan_clk_o[ch];
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(1'b0, rows[i][0], 8'h00);
      chk("reset value", 32'h0, q);
    end
    chk("oe", 32'h1, oe_o);
    foreach (rows[i]) begin
      wb(1'b1, rows[i][0], rows[i][1][7:0]);
      wb(1'b0, rows[i][0], 8'h00);
      chk("register", {16'h0, rows[i][2]}, q);
    end
    $display("done registers");
    wb(1'b1, 16'hfe0f, 8'h01);
    run <= 1'b1;
    wb(1'b1, 16'hfe0e, 8'h01);
    wb(1'b1, 16'hfe0a, 8'h3f);
    // Long enough for a leaked edge to reach the reference logic.
    repeat (3000) @(posedge clk_i);
    per(0, 200);
    wb(1'b1, 16'hfe0f, 8'h00);
    wb(1'b1, 16'hfe0e, 8'h00);
    wb(1'b1, 16'hfe0c, 8'h19);
    per(1, 2561);
    per(2, 520);
    per(0, 200);
    $display("done free run");
    wb(1'b1, 16'hfe0d, 8'h00);
    // Let the reference settle on the input period before measuring.
    repeat (1000) @(posedge clk_i);
    for (int c = 0; c < 3; c++) begin
      for (int m = 0; m < 4; m++) begin
        wb(1'b1, 16'hfe0e, 8'h01 << c);
        wb(1'b1, 16'(16'hfe0a + c), {m[1:0], 6'h00});
        repeat (3) rising(c);
        per(c, (m == 1) ? 200 : 400);
      end
    end
    $display("done multipliers");
    wb(1'b1, 16'hfe0e, 8'h01);
    wb(1'b1, 16'hfe0a, 8'h00);
    repeat (3) rising(0);
    rising(3);
    rising(0);
    a = n;
    chk_rng("latency", 97, 103, a);
    wb(1'b1, 16'hfe0d, 8'h03);
    repeat (3) rising(0);
    rising(3);
    rising(0);
    chk("delay step", 32'd30, n - a);
    $display("done delay");
    // Only A is synchronised, so A and C run at different rates.
    wb(1'b1, 16'hfe0e, 8'h09);
    follow(0);
    wb(1'b1, 16'hfe0e, 8'h01);
    follow(2);
    wb(1'b1, 16'hfe0f, 8'h08);
    @(posedge clk_i);
    chk("oe", 32'h0, oe_o);
    chk("sync out", 32'h0, out_o);
    $display("done sync output");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("chan", 32'h0, chan_clk_o);
    wb(1'b0, 16'hfe0e, 8'h00);
    chk("reset value", 32'h0, q);
    $display("done second reset");
    stop_test;
  end
endmodule // testbench

// ### verilog/sclk_chan.v
`timescale 1ns/1ps
`include "sclk_defines.vh"

// One channel's switching clock: free running from the frequency
// code, or restarted by the synchronisation reference.
module sclk_chan #(
  parameter PW = 12
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire [7:0]    freq_i,
  input  wire          sync_en_i,
  input  wire          ref_pulse_i,
  output reg           chan_clk_o
);

  // ****************************************************************
  // Period table in 8 ns cycles, code 63 first.
  // ****************************************************************
  localparam [64*12-1:0] PERIOD_TABLE = {
    12'h0c8, 12'h0cd, 12'h0d2, 12'h0d7, 12'h0dc, 12'h0e1, 12'h0e6,
    12'h0eb, 12'h0f0, 12'h0f5, 12'h0fa, 12'h0ff, 12'h104, 12'h109,
    12'h10e, 12'h113, 12'h118, 12'h11d, 12'h122, 12'h127, 12'h12c,
    12'h131, 12'h136, 12'h13b, 12'h140, 12'h14a, 12'h154, 12'h15e,
    12'h168, 12'h172, 12'h17c, 12'h186, 12'h190, 12'h1a4, 12'h1b8,
    12'h1cc, 12'h1e0, 12'h1f4, 12'h208, 12'h21c, 12'h230, 12'h244,
    12'h258, 12'h26c, 12'h280, 12'h2a8, 12'h2d0, 12'h2f8, 12'h320,
    12'h348, 12'h370, 12'h398, 12'h3c0, 12'h410, 12'h460, 12'h4b0,
    12'h4ff, 12'h5a0, 12'h641, 12'h6e1, 12'h780, 12'h820, 12'h8c0,
    12'ha01};

  reg  [PW-1:0] cnt_reg;
  reg  [PW-1:0] ref_cnt_reg;
  reg  [PW-1:0] ref_per_reg;
  wire [PW-1:0] nom_per;
  wire          mult_x2;
  wire [PW-1:0] sync_per;
  wire [PW-1:0] per;
  wire          mid_hit;
  wire          restart;
  wire [PW-1:0] cnt_next;

  assign nom_per = PERIOD_TABLE[freq_i[`SCLK_CODE_HI:0]*12 +: 12]; // [RL1]
  // Reserved multiplier codes fall back to the plain reference rate.
  assign mult_x2 = freq_i[`SCLK_MULT_HI:`SCLK_MULT_LO] == `SCLK_MULT_X2; // [RL7]
  // Until a reference period has been measured the code's rate runs.
  assign sync_per = (ref_per_reg < 2) ? nom_per :
                    (mult_x2 ? (ref_per_reg >> 1) : ref_per_reg); // [RL3]
  assign per = sync_en_i ? sync_per : nom_per; // [RL10]
  assign mid_hit = mult_x2 && (ref_per_reg >= 2) &&
                   (ref_cnt_reg + 1'b1 == (ref_per_reg >> 1)); // [RL7]
  assign restart = (sync_en_i && (ref_pulse_i || mid_hit)) ||
                   (cnt_reg + 1'b1 >= per); // [RL3]
  assign cnt_next = restart ? {PW{1'b0}} : cnt_reg + 1'b1;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg     <= {PW{1'b0}};
      ref_cnt_reg <= {PW{1'b0}};
      ref_per_reg <= {PW{1'b0}};
      chan_clk_o  <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      chan_clk_o <= cnt_next < (per >> 1);
      if (ref_pulse_i) begin
        ref_cnt_reg <= {PW{1'b0}};
        // A long gap saturates the measured period instead of wrapping.
        if (ref_cnt_reg != {PW{1'b1}}) begin
          ref_per_reg <= ref_cnt_reg + 1'b1;
        end else begin
          ref_per_reg <= ref_cnt_reg;
        end
      end else if (ref_cnt_reg != {PW{1'b1}}) begin
        ref_cnt_reg <= ref_cnt_reg + 1'b1;
      end
    end
  end

endmodule // sclk_chan

// ### verilog/sclk_top.v
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "sclk_defines.vh"

// Summary of operation
// RL1: Each channel's 6-bit code picks a fixed switching rate from a table that rises with the code.
// RL2: With sync on, the reference is the input's rising edge delayed by the programmed delay plus 760 ns.
// RL3: Each synchronised channel restarts its clock from the reference or a chosen multiple of it.
// RL4: The extra delay is an 8-bit count in which each step adds 80 ns.
// RL5: The sync output carries channel C's clock when the select bit is 0 and channel A's when it is 1.
// RL6: Bits 0, 1 and 2 enable synchronisation for channels A, B and C.
// RL7: Multiplier code 00 runs at the input rate, 01 at twice it, other codes are reserved.
// RL8: The shared input pin acts as sync input only while its function bit is 0.
// RL9: The shared output pin acts as sync output only while its function bit is 0.
// RL10: A channel without sync enabled runs freely at its coded rate and ignores the input.
module sclk_top #(
  parameter AW = 18,
  parameter PW = 12
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire [AW-1:0] adr_i,
  input  wire [31:0]   dat_i,
  output reg  [31:0]   dat_o,
  input  wire          we_i,
  input  wire [3:0]    sel_i,
  input  wire          cyc_i,
  input  wire          stb_i,
  output reg           ack_o,
  input  wire          shared_flag_sync_input_i,
  output wire [2:0]    chan_clk_o,
  output reg           shared_flag_sync_output_o,
  output reg           shared_flag_sync_output_oe_o
);

  // ****************************************************************
  // Timing counts derived from the clock period.
  // ****************************************************************
  // The propagation delay is a least time, so it rounds up.
  localparam [PW-1:0] PROP_CYC =
    (`SCLK_PROP_NS + `SCLK_CLK_NS - 1) / `SCLK_CLK_NS;
  localparam [PW-1:0] STEP_CYC =
    (`SCLK_STEP_NS + `SCLK_CLK_NS - 1) / `SCLK_CLK_NS;

  // ****************************************************************
  // Registers.
  // ****************************************************************
  reg  [7:0]    freq_reg [0:2];
  reg  [7:0]    delay_reg;
  reg  [7:0]    sync_ctl_reg;
  reg  [7:0]    pin_func_reg;

  reg           sync_meta_reg;
  reg           sync_sync_reg;
  reg           sync_prev_reg;
  reg           pend_reg;
  reg  [PW-1:0] dcnt_reg;
  reg           ref_pulse_reg;

  wire [15:0]   idx;
  wire          hit;
  wire          wr;
  reg  [7:0]    rd_next;
  wire          sync_edge;
  wire [PW-1:0] dly_cycles;
  wire          sync_output_pin_src;
  wire [7:0]    status;

  // ****************************************************************
  // Wishbone slave.
  // ****************************************************************
  // Ack is registered, so every access takes one wait state and the
  // ack drops by itself in the cycle after it was given.
  assign idx = adr_i[17:2];
  assign hit = cyc_i && stb_i && !ack_o;
  assign wr  = hit && we_i && sel_i[0];

  assign status = {3'h0, sync_sync_reg, pend_reg, chan_clk_o};

  always @* begin
    case (idx)
      `SCLK_IDX_FREQ_A:   rd_next = freq_reg[0];
      `SCLK_IDX_FREQ_B:   rd_next = freq_reg[1];
      `SCLK_IDX_FREQ_C:   rd_next = freq_reg[2];
      `SCLK_IDX_DELAY:    rd_next = delay_reg;
      `SCLK_IDX_SYNC_CTL: rd_next = sync_ctl_reg;
      `SCLK_IDX_PIN_FUNC: rd_next = pin_func_reg;
      `SCLK_IDX_STATUS:   rd_next = status;
      default:            rd_next = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= hit;
      if (hit && !we_i) begin
        dat_o <= {24'h00_0000, rd_next};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      freq_reg[0]  <= `SCLK_RST_BYTE;
      freq_reg[1]  <= `SCLK_RST_BYTE;
      freq_reg[2]  <= `SCLK_RST_BYTE;
      delay_reg    <= `SCLK_RST_BYTE;
      sync_ctl_reg <= `SCLK_RST_BYTE;
      pin_func_reg <= `SCLK_RST_BYTE;
    end else if (wr) begin
      case (idx)
        `SCLK_IDX_FREQ_A: begin
          freq_reg[0] <= dat_i[7:0];
        end
        `SCLK_IDX_FREQ_B: begin
          freq_reg[1] <= dat_i[7:0];
        end
        `SCLK_IDX_FREQ_C: begin
          freq_reg[2] <= dat_i[7:0];
        end
        `SCLK_IDX_DELAY: begin
          delay_reg <= dat_i[7:0]; // [RL4]
        end
        `SCLK_IDX_SYNC_CTL: begin
          sync_ctl_reg <= dat_i[7:0];
        end
        `SCLK_IDX_PIN_FUNC: begin
          pin_func_reg <= dat_i[7:0];
        end
        default: begin
          pin_func_reg <= pin_func_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sync input capture.
  // ****************************************************************
  // The pin is asynchronous to clk_i, so two flip-flops stand
  // before the edge detector.
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_meta_reg <= 1'b0;
      sync_sync_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      sync_meta_reg <= shared_flag_sync_input_i;
      sync_sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_sync_reg;
    end
  end

  // While the pin serves as a flag input its edges never reach the
  // reference logic.
  assign sync_edge = sync_sync_reg && !sync_prev_reg &&
                     !pin_func_reg[`SCLK_PIN_IN_BIT]; // [RL8]

  // ****************************************************************
  // Reference delay.
  // ****************************************************************
  assign dly_cycles = delay_reg * STEP_CYC + PROP_CYC; // [RL2] [RL4]

  // Only one edge is in flight at a time: an edge that arrives while
  // the previous one is still being delayed is dropped. With long
  // delays and fast inputs at most every other edge is therefore used, which
  // keeps the logic to a single counter.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg      <= 1'b0;
      dcnt_reg      <= {PW{1'b0}};
      ref_pulse_reg <= 1'b0;
    end else begin
      ref_pulse_reg <= 1'b0;
      if (pend_reg) begin
        if (dcnt_reg == {PW{1'b0}}) begin
          pend_reg      <= 1'b0;
          ref_pulse_reg <= 1'b1; // [RL2]
        end else begin
          dcnt_reg <= dcnt_reg - 1'b1;
        end
      end else if (sync_edge) begin
        pend_reg <= 1'b1;
        dcnt_reg <= dly_cycles - 1'b1; // [RL2]
      end
    end
  end

  // ****************************************************************
  // Channel clock generators.
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_chan
      sclk_chan #(
        .PW (PW)
      ) u_chan (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .freq_i      (freq_reg[g]),
        .sync_en_i   (sync_ctl_reg[g]), // [RL6] [RL10]
        .ref_pulse_i (ref_pulse_reg), // [RL3]
        .chan_clk_o  (chan_clk_o[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Sync output.
  // ****************************************************************
  assign sync_output_pin_src = sync_ctl_reg[`SCLK_SEL_BIT] ? chan_clk_o[0] :
                    chan_clk_o[2]; // [RL5]

  // In flag mode the pin is released; flag logic lives elsewhere.
  always @(posedge clk_i) begin
    if (rst_i) begin
      shared_flag_sync_output_o    <= 1'b0;
      shared_flag_sync_output_oe_o <= 1'b0;
    end else begin
      shared_flag_sync_output_o    <= sync_output_pin_src &&
        !pin_func_reg[`SCLK_PIN_OUT_BIT]; // [RL9]
      shared_flag_sync_output_oe_o <=
        !pin_func_reg[`SCLK_PIN_OUT_BIT]; // [RL9]
    end
  end

endmodule // sclk_top
